// >>> hw/timer_event_cfg.svh
// register map, field positions and reset values of the timer event-flag block
`ifndef TIMER_EVENT_CFG_SVH
`define TIMER_EVENT_CFG_SVH

// register byte offsets
`define CFG_OFS_CTRL       8'h00
`define CFG_OFS_MOD        8'h04
`define CFG_OFS_COUNT      8'h08
`define CFG_OFS_STATUS     8'h0c
`define CFG_OFS_MASK       8'h10
`define CFG_OFS_CH_BASE    8'h20
`define CFG_CH_STRIDE      8'h08
`define CFG_CH_VAL_OFS     8'h04

// field positions
`define CFG_CTRL_CENTER_BIT 0
`define CFG_CTRL_RUN_BIT    1
`define CFG_CHC_MODE_LSB    0
`define CFG_CHC_EDGE_LSB    2
`define CFG_STAT_OVF_BIT    0
`define CFG_STAT_CH_LSB     1

// reset values and counter limits
`define CFG_RST_CTRL       2'b00
`define CFG_RST_MOD        16'h0000
`define CFG_RST_CH_VAL     16'h0000
`define CFG_RST_CH_MODE    2'b00
`define CFG_RST_CH_EDGE    2'b00
`define CFG_CNT_TOP        16'hffff
`define CFG_CNT_ZERO       16'h0000
`define CFG_CNT_ONE        16'h0001

`endif

// >>> hw/timer_event_pkg.sv
// types shared by the timer event-flag block
package timer_event_pkg;

  // effective channel function, one-hot
  typedef enum logic [3:0]
  {
    MODE_CAPTURE    = 4'b0001,
    MODE_COMPARE    = 4'b0010,
    MODE_EDGE_PWM   = 4'b0100,
    MODE_CENTER_PWM = 4'b1000
  } chan_mode_t;

  // counting direction, one-hot
  typedef enum logic [1:0]
  {
    DIR_UP   = 2'b01,
    DIR_DOWN = 2'b10
  } count_dir_t;

  // capture edge choice {edge_select_high, edge_select_low}
  typedef enum logic [1:0]
  {
    EDGE_OFF  = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_ANY  = 2'h3
  } edge_sel_t;

endpackage

// >>> hw/timer_channel_event.sv
// one timer channel: pin synchroniser, edge detector and compare match
`timescale 1ns/1ps
module timer_channel_event
  import timer_event_pkg::*;
(
  input  wire logic        clk,           // timer clock
  input  wire logic        rst,           // async reset, active high
  input  wire logic        pin_async,     // channel pin, other domain
  input  wire chan_mode_t  mode,          // effective channel function
  input  wire logic [1:0]  edge_sel,      // capture edge choice
  input  wire logic [15:0] count,         // main counter value
  input  wire logic [15:0] value,         // channel value
  input  wire logic        count_run,     // counter is running
  output logic             hit_pulse,     // flag-setting event
  output logic             capture_pulse  // load count into value
);

  logic sync1_ff;
  logic sync2_ff;
  logic last_ff;
  logic rise;
  logic fall;
  logic edge_hit;
  logic match;

  // two-stage synchroniser; only sync2 and later are looked at
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      last_ff  <= 1'b0;
    end
    else
    begin
      sync1_ff <= pin_async;
      sync2_ff <= sync1_ff;
      last_ff  <= sync2_ff;
    end
  end

  // edge recognition on the synchronised level
  assign rise = sync2_ff & ~last_ff;
  assign fall = ~sync2_ff & last_ff;

  always_comb
  begin
    case (edge_sel_t'(edge_sel))
      EDGE_RISE: edge_hit = rise;
      EDGE_FALL: edge_hit = fall;
      EDGE_ANY:  edge_hit = rise | fall;
      default:   edge_hit = 1'b0;
    endcase
  end

  // match only while counting, so a stopped counter gives no repeats
  assign match = count_run & (count == value);

  // event source per function
  always_comb
  begin
    capture_pulse = 1'b0;
    case (mode)
      MODE_CAPTURE:
      begin
        hit_pulse     = edge_hit;
        capture_pulse = edge_hit;
      end
      MODE_COMPARE:    hit_pulse = match;
      MODE_EDGE_PWM:   hit_pulse = match;
      MODE_CENTER_PWM: hit_pulse = match;
      default:         hit_pulse = 1'b0;
    endcase
  end

endmodule // timer_channel_event

// >>> hw/timer_event_flags.sv
// timer counter, event flags, two-step flag clear and interrupt over apb
`timescale 1ns/1ps
`include "timer_event_cfg.svh"
module timer_event_flags
  import timer_event_pkg::*;
#(
  parameter int NUM_CH = 2 // number of timer channels
)
(
  input  wire logic              REF_CLK, // 100 MHz timer clock
  input  wire logic              RST,     // async reset, active high
  input  wire logic              PSEL,    // apb select
  input  wire logic              PENABLE, // apb access phase
  input  wire logic              PWRITE,  // apb direction, 1 = write
  input  wire logic [7:0]        PADDR,   // apb byte address
  input  wire logic [31:0]       PWDATA,  // apb write data
  output logic [31:0]            PRDATA,  // apb read data
  output logic                   PREADY,  // apb ready, always high
  output logic                   PSLVERR, // apb error, unmapped address
  input  wire logic [NUM_CH-1:0] CH_PIN,  // channel capture pins, async
  output logic                   IRQ      // level interrupt request
);

  localparam int NF = NUM_CH + 1; // overflow flag plus channel flags

  generate
    if (NUM_CH < 1 || NUM_CH > 8)
    begin : g_bad_num_ch
      $error("NUM_CH must lie in 1..8 to fit the register map");
    end
  endgenerate

  // apb phases
  logic setup;
  logic acc_wr;
  logic acc_rd;
  assign setup  = PSEL & ~PENABLE;
  assign acc_wr = PSEL & PENABLE & PWRITE;
  assign acc_rd = PSEL & PENABLE & ~PWRITE;
  assign PREADY = 1'b1;

  // configuration registers
  logic [1:0]  ctrl_ff;
  logic [1:0]  nxt_ctrl;
  logic [15:0] mod_ff;
  logic [15:0] nxt_mod;
  logic [NF-1:0] mask_ff;
  logic [NF-1:0] nxt_mask;
  logic [1:0]  ch_mode_ff [NUM_CH];
  logic [1:0]  nxt_ch_mode [NUM_CH];
  logic [1:0]  ch_edge_ff [NUM_CH];
  logic [1:0]  nxt_ch_edge [NUM_CH];
  logic [15:0] ch_val_ff [NUM_CH];
  logic [15:0] nxt_ch_val [NUM_CH];

  // counter state
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  count_dir_t  dir_ff;
  count_dir_t  nxt_dir;
  logic        ovf_evt;
  logic        center;
  logic        run;
  logic        cnt_wr;

  // flag state
  logic [NF-1:0] flag_ff;
  logic [NF-1:0] nxt_flag;
  logic [NF-1:0] armed_ff;
  logic [NF-1:0] nxt_armed;
  logic [NF-1:0] evt;
  logic [NF-1:0] clr;
  logic          irq_ff;
  logic          nxt_irq;

  // apb answer
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic        slverr_ff;
  logic        nxt_slverr;

  // per-channel hooks
  logic [NUM_CH-1:0] ch_hit;
  logic [NUM_CH-1:0] ch_cap;
  chan_mode_t        ch_fn [NUM_CH];

  assign center = ctrl_ff[`CFG_CTRL_CENTER_BIT];
  assign run    = ctrl_ff[`CFG_CTRL_RUN_BIT];
  assign cnt_wr = acc_wr & (PADDR == `CFG_OFS_COUNT);

  // channel function decode and event detectors
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++)
    begin : g_ch
      always_comb
      begin
        if (center)
          ch_fn[gi] = MODE_CENTER_PWM;
        else if (ch_mode_ff[gi] == 2'b00)
          ch_fn[gi] = MODE_CAPTURE;
        else if (ch_mode_ff[gi] == 2'b01)
          ch_fn[gi] = MODE_COMPARE;
        else
          ch_fn[gi] = MODE_EDGE_PWM;
      end

      timer_channel_event u_ch
      (
        .clk           (REF_CLK),
        .rst           (RST),
        .pin_async     (CH_PIN[gi]),
        .mode          (ch_fn[gi]),
        .edge_sel      (ch_edge_ff[gi]),
        .count         (cnt_ff),
        .value         (ch_val_ff[gi]),
        .count_run     (run),
        .hit_pulse     (ch_hit[gi]),
        .capture_pulse (ch_cap[gi])
      );
    end
  endgenerate

  // one event line per flag: overflow in bit 0, channels above
  assign evt = {ch_hit, ovf_evt};

  // counter next state; a count write restarts from zero going up
  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_dir = dir_ff;
    ovf_evt = 1'b0;
    if (cnt_wr)
    begin
      nxt_cnt = `CFG_CNT_ZERO;
      nxt_dir = DIR_UP;
    end
    else if (run && center)
    begin
      // modulus zero is not usable here; the counter then just wraps up
      case (dir_ff)
        DIR_UP:
        begin
          if (cnt_ff == mod_ff && mod_ff != `CFG_CNT_ZERO)
          begin
            nxt_cnt = cnt_ff - `CFG_CNT_ONE;
            nxt_dir = DIR_DOWN;
            ovf_evt = 1'b1;
          end
          else
            nxt_cnt = cnt_ff + `CFG_CNT_ONE;
        end
        DIR_DOWN:
        begin
          if (cnt_ff == `CFG_CNT_ZERO)
          begin
            nxt_cnt = `CFG_CNT_ONE;
            nxt_dir = DIR_UP;
          end
          else
            nxt_cnt = cnt_ff - `CFG_CNT_ONE;
        end
        default:
        begin
          nxt_cnt = `CFG_CNT_ZERO;
          nxt_dir = DIR_UP;
        end
      endcase
    end
    else if (run)
    begin
      nxt_dir = DIR_UP;
      if ((mod_ff != `CFG_CNT_ZERO && cnt_ff == mod_ff) || cnt_ff == `CFG_CNT_TOP)
      begin
        nxt_cnt = `CFG_CNT_ZERO;
        ovf_evt = 1'b1;
      end
      else
        nxt_cnt = cnt_ff + `CFG_CNT_ONE;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      cnt_ff <= `CFG_CNT_ZERO;
      dir_ff <= DIR_UP;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      dir_ff <= nxt_dir;
    end
  end

  // configuration writes; a capture beats a software write of the value
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_mod  = mod_ff;
    nxt_mask = mask_ff;
    if (acc_wr && PADDR == `CFG_OFS_CTRL)
      nxt_ctrl = PWDATA[1:0];
    if (acc_wr && PADDR == `CFG_OFS_MOD)
      nxt_mod = PWDATA[15:0];
    if (acc_wr && PADDR == `CFG_OFS_MASK)
      nxt_mask = PWDATA[NF-1:0];
    for (int i = 0; i < NUM_CH; i++)
    begin
      nxt_ch_mode[i] = ch_mode_ff[i];
      nxt_ch_edge[i] = ch_edge_ff[i];
      nxt_ch_val[i]  = ch_val_ff[i];
      if (acc_wr && PADDR == 8'(`CFG_OFS_CH_BASE + `CFG_CH_STRIDE * i))
      begin
        nxt_ch_mode[i] = PWDATA[`CFG_CHC_MODE_LSB +: 2];
        nxt_ch_edge[i] = PWDATA[`CFG_CHC_EDGE_LSB +: 2];
      end
      if (acc_wr && PADDR == 8'(`CFG_OFS_CH_BASE + `CFG_CH_STRIDE * i + `CFG_CH_VAL_OFS))
        nxt_ch_val[i] = PWDATA[15:0];
      if (ch_cap[i])
        nxt_ch_val[i] = cnt_ff;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      ctrl_ff <= `CFG_RST_CTRL;
      mod_ff  <= `CFG_RST_MOD;
      mask_ff <= '0;
      for (int i = 0; i < NUM_CH; i++)
      begin
        ch_mode_ff[i] <= `CFG_RST_CH_MODE;
        ch_edge_ff[i] <= `CFG_RST_CH_EDGE;
        ch_val_ff[i]  <= `CFG_RST_CH_VAL;
      end
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      mod_ff  <= nxt_mod;
      mask_ff <= nxt_mask;
      for (int i = 0; i < NUM_CH; i++)
      begin
        ch_mode_ff[i] <= nxt_ch_mode[i];
        ch_edge_ff[i] <= nxt_ch_edge[i];
        ch_val_ff[i]  <= nxt_ch_val[i];
      end
    end
  end

  // flags: arm on a read that returned one, clear on a later zero write.
  // arming uses the value actually returned, so a flag that rose between
  // setup and access cannot be cleared unseen.
  always_comb
  begin
    nxt_armed = armed_ff;
    if (acc_rd && PADDR == `CFG_OFS_STATUS)
      nxt_armed = armed_ff | (prdata_ff[NF-1:0] & flag_ff);
    clr = '0;
    if (acc_wr && PADDR == `CFG_OFS_STATUS)
    begin
      clr       = armed_ff & ~PWDATA[NF-1:0];
      nxt_armed = '0;
    end
    nxt_armed = nxt_armed & ~evt;
    nxt_flag  = (flag_ff & ~clr) | evt;
    nxt_irq   = |(nxt_flag & nxt_mask);
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      flag_ff  <= '0;
      armed_ff <= '0;
      irq_ff   <= 1'b0;
    end
    else
    begin
      flag_ff  <= nxt_flag;
      armed_ff <= nxt_armed;
      irq_ff   <= nxt_irq;
    end
  end

  assign IRQ = irq_ff;

  // read data and error latched in setup so the access phase needs no wait
  always_comb
  begin
    nxt_prdata = prdata_ff;
    nxt_slverr = slverr_ff;
    if (setup)
    begin
      nxt_prdata = 32'h0000_0000;
      nxt_slverr = 1'b0;
      if (PADDR == `CFG_OFS_CTRL)
        nxt_prdata[1:0] = ctrl_ff;
      else if (PADDR == `CFG_OFS_MOD)
        nxt_prdata[15:0] = mod_ff;
      else if (PADDR == `CFG_OFS_COUNT)
        nxt_prdata[15:0] = cnt_ff;
      else if (PADDR == `CFG_OFS_STATUS)
        nxt_prdata[NF-1:0] = flag_ff;
      else if (PADDR == `CFG_OFS_MASK)
        nxt_prdata[NF-1:0] = mask_ff;
      else
        nxt_slverr = 1'b1;
      for (int i = 0; i < NUM_CH; i++)
      begin
        if (PADDR == 8'(`CFG_OFS_CH_BASE + `CFG_CH_STRIDE * i))
        begin
          nxt_prdata[`CFG_CHC_MODE_LSB +: 2] = ch_mode_ff[i];
          nxt_prdata[`CFG_CHC_EDGE_LSB +: 2] = ch_edge_ff[i];
          nxt_slverr = 1'b0;
        end
        if (PADDR == 8'(`CFG_OFS_CH_BASE + `CFG_CH_STRIDE * i + `CFG_CH_VAL_OFS))
        begin
          nxt_prdata[15:0] = ch_val_ff[i];
          nxt_slverr = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      prdata_ff <= 32'h0000_0000;
      slverr_ff <= 1'b0;
    end
    else
    begin
      prdata_ff <= nxt_prdata;
      slverr_ff <= nxt_slverr;
    end
  end

  assign PRDATA  = prdata_ff;
  assign PSLVERR = slverr_ff;

endmodule // timer_event_flags

// >>> verif/timer_event_flags_chk.sv
// assertion checker for the timer event-flag block, bound to its ports
`timescale 1ns/1ps
`include "timer_event_cfg.svh"
module timer_event_flags_chk
#(
  parameter int NUM_CH = 2 // number of timer channels
)
(
  input wire logic              REF_CLK, // timer clock
  input wire logic              RST,     // async reset, active high
  input wire logic              PSEL,    // apb select
  input wire logic              PENABLE, // apb access phase
  input wire logic              PWRITE,  // apb direction
  input wire logic [7:0]        PADDR,   // apb byte address
  input wire logic [31:0]       PWDATA,  // apb write data
  input wire logic [31:0]       PRDATA,  // apb read data
  input wire logic              PREADY,  // apb ready
  input wire logic              PSLVERR, // apb error
  input wire logic [NUM_CH-1:0] CH_PIN,  // capture pins
  input wire logic              IRQ      // interrupt request
);
  logic setup; // apb setup cycle
  logic wr_st; // status write lands
  logic wr_sm; // status or mask write lands

  // decoded bus cycles
  assign setup = PSEL && !PENABLE;
  assign wr_st = PSEL && PENABLE && PWRITE && (PADDR == `CFG_OFS_STATUS);
  assign wr_sm = wr_st || (PSEL && PENABLE && PWRITE && (PADDR == `CFG_OFS_MASK));

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  sequence s_setup(logic [7:0] a);
    setup && (PADDR == a);
  endsequence
  sequence s_mask0;
    PSEL && PENABLE && PWRITE && (PADDR == `CFG_OFS_MASK) && (PWDATA[NUM_CH:0] == '0);
  endsequence

  property p_ready; PREADY; endproperty
  property p_err_unmapped; s_setup(8'h14) |=> PSLVERR; endproperty
  property p_err_mapped; s_setup(`CFG_OFS_STATUS) |=> !PSLVERR; endproperty
  property p_err_cause; $rose(PSLVERR) |-> $past(setup); endproperty
  property p_mask_off; s_mask0 |=> ##1 !IRQ; endproperty
  // a request only drops after software touches status or mask
  property p_irq_drop; $fell(IRQ) |-> $past(wr_sm) || $past(wr_sm, 2); endproperty
  property p_ones_keep; IRQ && wr_st && (&PWDATA[NUM_CH:0]) |=> IRQ [*2]; endproperty
  property p_hi_zero;
    PSEL && PENABLE && !PWRITE && (PADDR == `CFG_OFS_STATUS) |-> PRDATA[31:NUM_CH+1] == '0;
  endproperty
  property p_rst_quiet; $fell(RST) |-> !IRQ && !PSLVERR; endproperty

  a_ready: assert property (p_ready) else $error("ready low");
  a_err_unmapped: assert property (p_err_unmapped) else $error("no error on hole");
  a_err_mapped: assert property (p_err_mapped) else $error("error on status");
  a_err_cause: assert property (p_err_cause) else $error("error without setup");
  a_mask_off: assert property (p_mask_off) else $error("irq with mask zero");
  a_irq_drop: assert property (p_irq_drop) else $error("irq fell unasked");
  a_ones_keep: assert property (p_ones_keep) else $error("one write cleared");
  a_hi_zero: assert property (p_hi_zero) else $error("extra status bits");
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs after reset");
endmodule // timer_event_flags_chk

bind timer_event_flags timer_event_flags_chk #(.NUM_CH(NUM_CH)) u_chk
(
  .REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .CH_PIN(CH_PIN), .IRQ(IRQ)
);

// >>> verif/testbench.sv
// self-checking bench: apb register tasks and flag scenarios
`timescale 1ns/1ps
`include "timer_event_cfg.svh"
module testbench;
  logic        REF_CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ, er, dn;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, rd, prev;
  logic [1:0]  CH_PIN;
  int          n_fail, n_tests, k, e;

  timer_event_flags #(.NUM_CH(2)) DUT
  (
    .REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .CH_PIN(CH_PIN), .IRQ(IRQ)
  );

  // 100 mhz clock
  initial
  begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end

  task automatic test_done();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; read data and error taken at the ready edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    PSEL   <= 1'b1;
    PWRITE <= w;
    PADDR  <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge REF_CLK);
      if (PREADY === 1'b1)
        break;
    end
    if (i == 16)
    begin
      n_fail++;
      test_done();
    end
    rd = PRDATA;
    er = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    // idle edge, so a following call never re-drives psel in this step
    @(posedge REF_CLK);
  endtask

  // clearing needs a read first, so do both steps
  task automatic clr();
    xfer(1'b0, `CFG_OFS_STATUS, 32'h0);
    xfer(1'b1, `CFG_OFS_STATUS, 32'h0);
  endtask

  task automatic run(input logic [31:0] ctrl, input int n);
    xfer(1'b1, `CFG_OFS_COUNT, 32'h0);
    xfer(1'b1, `CFG_OFS_CTRL, ctrl);
    repeat (n) @(posedge REF_CLK);
  endtask

  // irq is registered, so give it two edges to settle
  task automatic irq_after(input logic [7:0] a, input logic [31:0] d, input logic x);
    xfer(1'b1, a, d);
    repeat (2) @(posedge REF_CLK);
    check(IRQ, x);
  endtask

  // main sequence
  initial
  begin
    RST = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    CH_PIN = 2'b00;
    n_fail = 0;
    n_tests = 0;
    repeat (3) @(posedge REF_CLK);
    RST <= 1'b0;
    @(posedge REF_CLK);
    for (k = 0; k < 9; k++)
    begin
      xfer(1'b0, 8'(k * 4 + (k > 4 ? 12 : 0)), 32'h0);
      check(rd, 32'h0);
    end
    xfer(1'b0, 8'h14, 32'h0);
    check({rd[30:0], er}, 32'h1);
    // free run: no overflow before 0xffff, one after the wrap
    run(32'h2, 65500);
    xfer(1'b0, `CFG_OFS_STATUS, 32'h0);
    check(rd[0], 1'b0);
    repeat (100) @(posedge REF_CLK);
    xfer(1'b0, `CFG_OFS_STATUS, 32'h0);
    check(rd[0], 1'b1);
    xfer(1'b1, `CFG_OFS_CTRL, 32'h0);
    irq_after(`CFG_OFS_MASK, 32'h0, 1'b0);
    irq_after(`CFG_OFS_MASK, 32'h2, 1'b0);
    irq_after(`CFG_OFS_MASK, 32'h1, 1'b1);
    irq_after(`CFG_OFS_MASK, 32'h0, 1'b0);
    irq_after(`CFG_OFS_MASK, 32'h1, 1'b1);
    irq_after(`CFG_OFS_STATUS, 32'hffffffff, 1'b1);
    irq_after(`CFG_OFS_STATUS, 32'h0, 1'b1);
    xfer(1'b0, `CFG_OFS_STATUS, 32'h0);
    irq_after(`CFG_OFS_STATUS, 32'h0, 1'b0);
    xfer(1'b0, `CFG_OFS_STATUS, 32'h0);
    check(rd, 32'h0);
    // new overflow between read and zero write keeps the flag
    xfer(1'b1, `CFG_OFS_MOD, 32'h4);
    run(32'h2, 8);
    xfer(1'b0, `CFG_OFS_STATUS, 32'h0);
    check(rd[0], 1'b1);
    repeat (8) @(posedge REF_CLK);
    xfer(1'b1, `CFG_OFS_CTRL, 32'h0);
    irq_after(`CFG_OFS_STATUS, 32'h0, 1'b1);
    clr();
    // compare then edge pwm; channel 1 value above modulus never matches
    xfer(1'b1, `CFG_OFS_MOD, 32'h10);
    for (k = 1; k < 3; k++)
    begin
      xfer(1'b1, 8'h20, 32'(k));
      xfer(1'b1, 8'h24, 32'h3);
      xfer(1'b1, 8'h28, 32'(k));
      xfer(1'b1, 8'h2c, 32'h20);
      run(32'h2, 40);
      xfer(1'b1, `CFG_OFS_CTRL, 32'h0);
      xfer(1'b0, `CFG_OFS_STATUS, 32'h0);
      check(rd[2:1], 2'b01);
      clr();
    end
    // capture on both channels for every edge choice
    for (e = 0; e < 4; e++)
    begin
      xfer(1'b1, 8'h20, 32'(e << 2));
      xfer(1'b1, 8'h28, 32'(e << 2));
      clr();
      CH_PIN <= 2'b11;
      repeat (6) @(posedge REF_CLK);
      xfer(1'b0, `CFG_OFS_STATUS, 32'h0);
      check(rd, {29'h0, {2{e[0]}}, 1'b0});
      clr();
      CH_PIN <= 2'b00;
      repeat (6) @(posedge REF_CLK);
      xfer(1'b0, `CFG_OFS_STATUS, 32'h0);
      check(rd, {29'h0, {2{e[1]}}, 1'b0});
      clr();
    end
    // center mode: reads three edges apart must see a step down by three;
    // channel 0 value below modulus, so it matches going up and going down
    xfer(1'b1, `CFG_OFS_MOD, 32'h8);
    xfer(1'b1, 8'h24, 32'h4);
    run(32'h3, 0);
    dn = 1'b0;
    for (k = 0; k < 24; k++)
    begin
      prev = rd;
      xfer(1'b0, `CFG_OFS_COUNT, 32'h0);
      if (k > 0 && prev - rd == 32'h3)
        dn = 1'b1;
    end
    check(dn, 1'b1);
    xfer(1'b1, `CFG_OFS_CTRL, 32'h0);
    xfer(1'b0, `CFG_OFS_STATUS, 32'h0);
    check(rd[1:0], 2'b11);
    test_done();
  end
endmodule // testbench
